// ---- rtl/ilo_core.v ----
// Operation
// - disabled mode uses literal access or bank
// - enabled a=0 low operand adds pointer two
// - only operands up to 5Fh become offsets
// - applies to all access-bit opcodes
// - zero pointer reproduces original access map
// - indexed add, destination by d, flags
// - indexed bit set, flags untouched
// - indexed fill with ones, flags untouched
// - one enable switches addressing only; the set decodes in both modes
// - d keeps its usual destination meaning
// - extension bit resets to disabled
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ilo_regs.vh"

module ilo_core (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // Avalon-MM slave
    input  wire [7:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    // Mode indication
    output reg         o_ext_enable,
    output reg         o_exec_pulse
);

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    // One-hot, so each state is a single flip-flop
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Data memory is not reset; software loads it before use
    reg  [7:0]  mem [0:`ILO_MEM_DEPTH-1];
    reg  [11:0] ptr2;
    reg  [3:0]  bank;
    reg  [7:0]  wreg;
    reg  [4:0]  status;
    reg  [15:0] opcode;
    reg  [11:0] last_addr;
    reg         last_indexed;
    reg         last_has_a;
    reg         last_exec;
    reg  [11:0] maddr;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [31:0] next_readdata;

    wire [11:0] eff_addr;
    wire        has_a;
    wire        indexed;
    wire [7:0]  alu_result;
    wire [4:0]  alu_status;
    wire [7:0]  mem_rd = mem[eff_addr];

    // Bus request taken at this edge
    wire req   = i_read || i_write;
    wire taken = req && !o_waitrequest;
    wire wr_en = taken && i_write;

    // Byte lane masks, one byte of mask for each of lanes 0 and 1
    wire [15:0] m16;
    wire [11:0] m01 = m16[11:0];

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_lane
            // Each mask bit follows the enable of its own byte lane
            assign m16[g] = i_byteenable[g / 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    // Only these three opcodes change data; every other opcode is
    // decoded for its address alone and leaves W, flags and memory
    wire op_add    = (opcode[15:10] == `ILO_OP_ADD);
    wire op_bitset = (opcode[15:12] == `ILO_OP_BITSET);
    wire op_fill   = (opcode[15:9] == `ILO_OP_FILL);
    wire op_any    = op_add || op_bitset || op_fill;
    wire to_w    = op_add && !opcode[9];

    // ------------------------------------------------------------
    // Address decode and data path
    // ------------------------------------------------------------
    // The mode enable feeds the decoder straight from its register,
    // so a change takes effect from the next instruction on
    ilo_addr_map u_map (
        .i_opcode   (opcode),
        .i_ext_en   (o_ext_enable),
        .i_ptr2     (ptr2),
        .i_bank     (bank),
        .o_eff_addr (eff_addr),
        .o_has_a    (has_a),
        .o_indexed  (indexed)
    );

    // The ALU works on the byte at the decoded address in the same
    // cycle, so an instruction needs no separate read cycle
    ilo_alu u_alu (
        .i_add      (op_add),
        .i_bitset   (op_bitset),
        .i_fill     (op_fill),
        .i_bit      (opcode[11:9]),
        .i_w        (wreg),
        .i_mem      (mem_rd),
        .i_status   (status),
        .o_result   (alu_result),
        .o_status   (alu_status)
    );

    // ------------------------------------------------------------
    // Execution sequencer
    // ------------------------------------------------------------

    // Next state
    // An instruction write is the only way into the execute state,
    // and the execute state always lasts exactly one cycle
    always @* begin
        case (state)
            ST_IDLE: begin
                if (wr_en && (i_address == `ILO_OFS_INSTR))
                    next_state = ST_EXEC;
                else
                    next_state = ST_IDLE;
            end
            ST_EXEC: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always @(posedge i_clk) begin
        if (i_rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Execute pulse output
    // Registered so the output comes straight from a flip-flop;
    // it therefore trails the execute cycle by one clock
    always @(posedge i_clk) begin
        if (i_rst)
            o_exec_pulse <= 1'b0;
        else
            o_exec_pulse <= (state == ST_EXEC);
    end

    // Data memory write port
    // Execute has priority over the bus; the handshake keeps a bus
    // write from being taken in the execute cycle, so none is lost
    // and the decoded address never races a software pointer change
    always @(posedge i_clk) begin
        if ((state == ST_EXEC) && op_any && !to_w) begin
            mem[eff_addr] <= alu_result;
        end else if (wr_en && (i_address == `ILO_OFS_MDATA) && i_byteenable[0]) begin
            mem[maddr] <= i_writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Avalon handshake
    // ------------------------------------------------------------

    // One wait cycle, held off while executing
    // Waitrequest drops only when the sequencer is idle and will stay
    // idle, so nothing is taken while an instruction is in flight; each
    // taken request raises it again for at least one cycle
    always @(posedge i_clk) begin
        if (i_rst)
            o_waitrequest <= 1'b1;
        else if (req && o_waitrequest && (state == ST_IDLE) && (next_state == ST_IDLE))
            o_waitrequest <= 1'b0;
        else
            o_waitrequest <= 1'b1;
    end

    // Read data mux
    // Unmapped offsets and unused upper bits read as zero
    always @* begin
        next_readdata = 32'h00000000;
        case (i_address)
            `ILO_OFS_CTRL:   next_readdata[0] = o_ext_enable;
            `ILO_OFS_PTR2:   next_readdata[11:0] = ptr2;
            `ILO_OFS_BANK:   next_readdata[3:0] = bank;
            `ILO_OFS_WREG:   next_readdata[7:0] = wreg;
            `ILO_OFS_STATUS: next_readdata[4:0] = status;
            `ILO_OFS_INSTR:  next_readdata[15:0] = opcode;
            `ILO_OFS_EADDR: begin
                next_readdata[11:0]            = last_addr;
                next_readdata[`ILO_EA_INDEXED] = last_indexed;
                next_readdata[`ILO_EA_HAS_A]   = last_has_a;
                next_readdata[`ILO_EA_EXEC]    = last_exec;
            end
            `ILO_OFS_MADDR:  next_readdata[11:0] = maddr;
            `ILO_OFS_MDATA:  next_readdata[7:0] = mem[maddr];
            default:         next_readdata = 32'h00000000;
        endcase
    end

    // Read data stands while waitrequest is low
    // Loaded in the cycle before the read is taken, from registers
    // that cannot change in that cycle
    always @(posedge i_clk) begin
        if (i_rst)
            o_readdata <= 32'h00000000;
        else if (i_read && o_waitrequest)
            o_readdata <= next_readdata;
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------

    // Control and address registers
    // Lanes 0 and 1 gate the 12-bit and 16-bit fields byte by byte
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_enable <= `ILO_EXT_RST;
            ptr2         <= `ILO_PTR_RST;
            bank         <= `ILO_BANK_RST;
            maddr        <= `ILO_PTR_RST;
            opcode       <= `ILO_OP_RST;
        end else if (wr_en) begin
            case (i_address)
                `ILO_OFS_CTRL:
                    if (i_byteenable[0])
                        o_ext_enable <= i_writedata[`ILO_CTRL_EXT];
                `ILO_OFS_PTR2:
                    ptr2 <= (ptr2 & ~m01) | (i_writedata[11:0] & m01);
                `ILO_OFS_BANK:
                    if (i_byteenable[0])
                        bank <= i_writedata[3:0];
                `ILO_OFS_MADDR:
                    maddr <= (maddr & ~m01) | (i_writedata[11:0] & m01);
                `ILO_OFS_INSTR:
                    opcode <= (opcode & ~m16) | (i_writedata[15:0] & m16);
                default: ;
            endcase
        end
    end

    // Working register and flags
    // Execute and a bus write never meet: waitrequest is high
    // throughout the execute cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            wreg   <= `ILO_BYTE_RST;
            status <= `ILO_ST_RST;
        end else if (state == ST_EXEC) begin
            // sum to W when d is 0
            if (to_w)
                wreg <= alu_result;
            status <= alu_status;
        end else if (wr_en && i_byteenable[0]) begin
            if (i_address == `ILO_OFS_WREG)
                wreg <= i_writedata[7:0];
            if (i_address == `ILO_OFS_STATUS)
                status <= i_writedata[4:0];
        end
    end

    // Last decoded address record
    // Kept for software, so the decode of the last instruction
    // can be read back after it has run
    always @(posedge i_clk) begin
        if (i_rst) begin
            last_addr    <= `ILO_PTR_RST;
            last_indexed <= 1'b0;
            last_has_a   <= 1'b0;
            last_exec    <= 1'b0;
        end else if (state == ST_EXEC) begin
            last_addr    <= eff_addr;
            last_indexed <= indexed;
            last_has_a   <= has_a;
            last_exec    <= op_any;
        end
    end

endmodule // ilo_core
`default_nettype wire

// ---- rtl/ilo_regs.vh ----
`ifndef ILO_REGS_VH
`define ILO_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ILO_OFS_CTRL    8'h00
`define ILO_OFS_PTR2    8'h04
`define ILO_OFS_BANK    8'h08
`define ILO_OFS_WREG    8'h0C
`define ILO_OFS_STATUS  8'h10
`define ILO_OFS_INSTR   8'h14
`define ILO_OFS_EADDR   8'h18
`define ILO_OFS_MADDR   8'h1C
`define ILO_OFS_MDATA   8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ILO_CTRL_EXT    0
`define ILO_ST_C        0
`define ILO_ST_DIGIT    1
`define ILO_ST_Z        2
`define ILO_ST_OVF      3
`define ILO_ST_N        4
`define ILO_EA_INDEXED  16
`define ILO_EA_HAS_A    17
`define ILO_EA_EXEC     18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ILO_EXT_RST     1'b0
`define ILO_PTR_RST     12'h000
`define ILO_BANK_RST    4'h0
`define ILO_BYTE_RST    8'h00
`define ILO_ST_RST      5'h00
`define ILO_OP_RST      16'h0000

// ----------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------
`define ILO_ACC_LIMIT   8'h5F
`define ILO_ACC_HIBANK  4'hF
`define ILO_OP_ADD      6'h09
`define ILO_OP_BITSET   4'h8
`define ILO_OP_FILL     7'h34
`define ILO_FILL        8'hFF
`define ILO_MEM_DEPTH   4096

`endif

// ---- rtl/ilo_addr_map.v ----
`timescale 1ns/10ps
`default_nettype none
`include "ilo_regs.vh"

module ilo_addr_map (
    // Instruction and mode
    input  wire [15:0] i_opcode,
    input  wire        i_ext_en,
    // Address sources
    input  wire [11:0] i_ptr2,
    input  wire [3:0]  i_bank,
    // Decoded address
    output reg  [11:0] o_eff_addr,
    output wire        o_has_a,
    output wire        o_indexed
);

    wire [7:0] file_f = i_opcode[7:0];
    wire       acc_a  = i_opcode[8];
    wire [3:0] hi     = i_opcode[15:12];

    assign o_has_a = ((hi >= 4'h1) && (hi <= 4'hB)) ||
                     (i_opcode[15:9] == 7'h01) ||
                     (i_opcode[15:10] == 6'h01);

    assign o_indexed = o_has_a && i_ext_en && !acc_a &&
                       (file_f <= `ILO_ACC_LIMIT);

    // Effective address selection
    always @* begin
        if (o_indexed) begin
            o_eff_addr = i_ptr2 + {4'h0, file_f};
        end else if (acc_a) begin
            o_eff_addr = {i_bank, file_f};
        end else if (file_f <= `ILO_ACC_LIMIT) begin
            o_eff_addr = {4'h0, file_f};
        end else begin
            o_eff_addr = {`ILO_ACC_HIBANK, file_f};
        end
    end

endmodule // ilo_addr_map
`default_nettype wire

// ---- rtl/ilo_alu.v ----
`timescale 1ns/10ps
`default_nettype none
`include "ilo_regs.vh"

module ilo_alu (
    // Operation select
    input  wire       i_add,
    input  wire       i_bitset,
    input  wire       i_fill,
    input  wire [2:0] i_bit,
    // Operands
    input  wire [7:0] i_w,
    input  wire [7:0] i_mem,
    input  wire [4:0] i_status,
    // Results
    output reg  [7:0] o_result,
    output reg  [4:0] o_status
);

    wire [8:0] sum    = {1'b0, i_w} + {1'b0, i_mem};
    wire [4:0] lo_sum = {1'b0, i_w[3:0]} + {1'b0, i_mem[3:0]};

    // Result and flags per operation
    always @* begin
        o_result = i_mem;
        o_status = i_status;
        if (i_add) begin
            o_result = sum[7:0];
            o_status[`ILO_ST_C]  = sum[8];
            o_status[`ILO_ST_DIGIT] = lo_sum[4];
            o_status[`ILO_ST_Z]  = (sum[7:0] == 8'h00);
            o_status[`ILO_ST_N]  = sum[7];
            o_status[`ILO_ST_OVF] = (i_w[7] == i_mem[7]) && (sum[7] != i_w[7]);
        end else if (i_bitset) begin
            o_result = i_mem | (8'h01 << i_bit);
        end else if (i_fill) begin
            o_result = `ILO_FILL;
        end
    end

endmodule // ilo_alu
`default_nettype wire

// ---- verification/ilo_core_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none

module ilo_core_monitor (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Avalon-MM slave
    input wire logic [7:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    // Mode indication
    input wire logic        o_ext_enable,
    input wire logic        o_exec_pulse
);
    // ------------------------------------------------------------
    // Taken writes
    // ------------------------------------------------------------
    wire tk_w    = i_write & ~o_waitrequest;
    wire ctrl_w  = tk_w & (i_address == 8'h00) & i_byteenable[0];
    wire instr_w = tk_w & (i_address == 8'h14);

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Instruction write and its execute steps
    sequence s_instr_take;
        instr_w;
    endsequence
    sequence s_exec_stall;
        o_waitrequest [*2];
    endsequence

    ext_reset_a: assert property ($fell(i_rst) |-> !o_ext_enable && o_waitrequest)
        else $error("mode or handshake not idle after reset");
    ext_write_a: assert property (ctrl_w |=> o_ext_enable == $past(i_writedata[0]))
        else $error("mode enable does not follow control write");
    ext_hold_a: assert property (!ctrl_w |=> $stable(o_ext_enable))
        else $error("mode enable changed without control write");
    exec_follow_a: assert property (s_instr_take |-> ##2 o_exec_pulse)
        else $error("no execute pulse two cycles after instruction");
    exec_cause_a: assert property (o_exec_pulse |-> $past(instr_w, 2))
        else $error("execute pulse without instruction write");
    exec_single_a: assert property (o_exec_pulse |=> !o_exec_pulse)
        else $error("execute pulse longer than one cycle");
    exec_stall_a: assert property (s_instr_take |=> s_exec_stall)
        else $error("bus not stalled for execute cycle");
    bus_answer_a: assert property ((i_read || i_write) |-> ##[0:3] !o_waitrequest)
        else $error("bus request not answered in time");
endmodule // ilo_core_monitor

bind ilo_core ilo_core_monitor mon_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_ext_enable(o_ext_enable), .o_exec_pulse(o_exec_pulse)
);

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic        i_clk        = 1'b0;
    logic        i_rst        = 1'b1;
    logic [7:0]  i_address    = 8'h00;
    logic        i_read       = 1'b0;
    logic        i_write      = 1'b0;
    logic [31:0] i_writedata  = 32'h00000000;
    logic [3:0]  i_byteenable = 4'hF;
    logic [31:0] o_readdata;
    logic        o_waitrequest;
    logic        o_ext_enable;
    logic        o_exec_pulse;
    int          n_errors     = 0;
    int          checked      = 0;
    int          n_exec       = 0;
    logic [31:0] exp_q[$];

    ilo_core dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_ext_enable(o_ext_enable), .o_exec_pulse(o_exec_pulse)
    );

    // Clock at 40 MHz
    always #12.5 i_clk = ~i_clk;

    // Execute pulses seen, one per instruction write
    always @(posedge i_clk) begin
        if (o_exec_pulse === 1'b1)
            n_exec++;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("Checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        k = 0;
        @(posedge i_clk);
        i_read       <= rd;
        i_write      <= ~rd;
        i_address    <= a;
        i_writedata  <= d;
        i_byteenable <= be;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 20);
        i_read  <= 1'b0;
        i_write <= 1'b0;
        if (k >= 20) begin
            n_errors++;
            $display("Error at %0t: bus wait timed out", $time);
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hF);
    endtask

    // Read with expected value noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h00000000, 4'hF);
    endtask

    // ------------------------------------------------------------
    // Watcher: compares each taken read with the oldest note
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_read && o_waitrequest === 1'b0) begin
            if (exp_q.size() == 0)
                check(o_readdata, 32'hDEADBEEF);
            else
                check(o_readdata, exp_q.pop_front());
        end
    end

    // Effective address expected from mode, pointer and bank
    function automatic logic [11:0] ea(logic [15:0] op, logic ext, logic [11:0] p,
                                       logic [3:0] b);
        if (op[8])
            return {b, op[7:0]};
        if (ext && op[7:0] <= 8'h5F)
            return p + {4'h0, op[7:0]};
        return {(op[7:0] <= 8'h5F) ? 4'h0 : 4'hF, op[7:0]};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [15:0] op;
        logic [11:0] ptr, addr;
        logic [7:0]  f, w, m, w2, m2, r;
        logic [8:0]  s9;
        logic [4:0]  st, st2;
        logic [3:0]  bnk, nib;
        logic        ext, a, ex, idx, has;
        int          kind;
        void'($urandom(32'h4a1c4fe7));
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values, unmapped place, disabled lane
        for (int o = 0; o <= 8'h1C; o += 4)
            rd(8'(o), 32'h00000000);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h00000000);
        bus(1'b0, 8'h08, 32'h0000000F, 4'h0);
        rd(8'h08, 32'h00000000);
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            ext = $urandom;
            ptr = $urandom;
            bnk = $urandom;
            w = $urandom;
            m = $urandom;
            st = $urandom;
            kind = $urandom % 5;
            f = (i % 4 == 0) ? ((i % 8 == 0) ? 8'h5F : 8'h60) : 8'($urandom);
            // indexed forms mostly encoded with a zero
            a = ($urandom % 3 == 0);
            if (i == 1) begin
                ptr = 12'h000;
                ext = 1'b1;
            end
            // Top nibbles C to F carry no access bit
            nib = 4'h1 + 4'($urandom % 15);
            if (nib == 4'h2 || nib == 4'h6 || nib == 4'h8)
                nib = 4'h5;
            case (kind)
                0: op = {7'b0010010, a, f};
                1: op = {7'b0010011, a, f};
                2: op = {4'h8, 3'($urandom), a, f};
                3: op = {7'b0110100, a, f};
                default: op = {nib, 3'($urandom), a, f};
            endcase
            has = (kind < 4) || (nib <= 4'hB);
            addr = ea(op, ext && has, ptr, bnk);
            idx = has && ext && !a && f <= 8'h5F;
            ex = (kind < 4);
            w2 = w;
            m2 = m;
            st2 = st;
            s9 = {1'b0, w} + {1'b0, m};
            r = s9[7:0];
            case (kind)
                0, 1: begin
                    st2 = {r[7], (w[7] == m[7]) && (r[7] != w[7]), r == 8'h00,
                           ({1'b0, w[3:0]} + {1'b0, m[3:0]}) > 5'h0F, s9[8]};
                    if (kind == 0) w2 = r;
                    else m2 = r;
                end
                2: m2 = m | (8'h01 << op[11:9]);
                3: m2 = 8'hFF;
                default: ;
            endcase
            wr(8'h00, {31'h0, ext});
            wr(8'h04, {20'h0, ptr});
            wr(8'h08, {28'h0, bnk});
            wr(8'h0C, {24'h0, w});
            wr(8'h10, {27'h0, st});
            wr(8'h1C, {20'h0, addr});
            wr(8'h20, {24'h0, m});
            wr(8'h14, {16'h0, op});
            rd(8'h18, {13'h0, ex, has, idx, 4'h0, addr});
            rd(8'h0C, {24'h0, w2});
            rd(8'h20, {24'h0, m2});
            rd(8'h10, {27'h0, st2});
            rd(8'h00, {31'h0, ext});
            check({31'h0, o_ext_enable}, {31'h0, ext});
        end
        $display("random test done");
        // Mid-run reset with the extension on must turn it off again
        wr(8'h00, 32'h00000001);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(8'h00, 32'h00000000);
        rd(8'h04, 32'h00000000);
        $display("mid reset test done");
        repeat (3) @(posedge i_clk);
        check(32'(exp_q.size()), 32'h00000000);
        check(32'(n_exec), 32'h0000003C);
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
